/* File: src/crf_rx_flags.sv */
// Receive flags, interrupt enables and status fields behind an AXI4-Lite slave
`timescale 1ns/10ps
module crf_rx_flags (
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // CAN core side, same clock
   input wire crf_pkg::crf_events_t core_events,
   input wire logic [8:0] tx_error_count,
   input wire logic [7:0] rx_error_count,
   output logic shift_foreground, // Pulse: next FIFO entry moved into foreground buffer
   output logic irq_wakeup,
   output logic irq_error,
   output logic irq_receive,
   output logic irq
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Transmitter encoding from its counter
   // counter to code
   function automatic crf_pkg::crf_state_t tx_code(input logic [8:0] cnt);
      if (cnt > crf_pkg::LIMIT_BUSOFF) return crf_pkg::ST_BUSOFF;
      else if (cnt > crf_pkg::LIMIT_ERR) return crf_pkg::ST_ERR;
      else if (cnt > crf_pkg::LIMIT_WARN) return crf_pkg::ST_WARN;
      else return crf_pkg::ST_OK;
   endfunction : tx_code

   // Whether a change old->new matters for a sensitivity code
   function automatic logic sens_hit(input logic [1:0] sens, input crf_pkg::crf_state_t o,
                                     input crf_pkg::crf_state_t n);
      logic boff;
      logic err;
      boff = (o == crf_pkg::ST_BUSOFF) != (n == crf_pkg::ST_BUSOFF);
      err = (o >= crf_pkg::ST_ERR) != (n >= crf_pkg::ST_ERR);
      case (sens)
         2'h0: return 1'b0;
         2'h1: return boff;
         2'h2: return boff | err;
         2'h3: return o != n;
         default: return 1'b0;
      endcase
   endfunction : sens_hit

   crf_pkg::crf_state_all_t st_r;
   crf_pkg::crf_state_all_t st_nxt;
   crf_pkg::crf_state_t rx_live; // Receiver state the counters say now
   crf_pkg::crf_state_t tx_live; // Transmitter state the counters say now
   logic in_init; // Initialization mode active
   logic out_init; // Flags and enables registers writable
   logic [7:0] flags_rd; // Flags register as software reads it
   logic [7:0] clear_mask; // Write-one-to-clear bits of the current write
   logic do_write; // Both write halves held; apply this cycle

   // ----------------------------------------
   // Live states
   // ----------------------------------------
   // bus-off mirrored into receiver
   always_comb begin
      tx_live = tx_code(tx_error_count);
      if (tx_live == crf_pkg::ST_BUSOFF) begin
         rx_live = crf_pkg::ST_BUSOFF;
      end else if ({1'b0, rx_error_count} > crf_pkg::LIMIT_ERR) begin
         rx_live = crf_pkg::ST_ERR;
      end else if ({1'b0, rx_error_count} > crf_pkg::LIMIT_WARN) begin
         rx_live = crf_pkg::ST_WARN;
      end else begin
         rx_live = crf_pkg::ST_OK;
      end
   end

   assign in_init = st_r.init_request & st_r.init_acknowledge;
   assign out_init = ~st_r.init_request & ~st_r.init_acknowledge;
   // state fields have no write path
   assign flags_rd = {st_r.flags.wakeup, st_r.flags.status_change,
                      st_r.receiver_state_field, st_r.transmitter_state_field,
                      st_r.flags.overrun, st_r.flags.rx_full};
   // Handshakes combinational from the bus state
   // Reads wait while a write half is held or offered, so one transfer runs at a time
   assign s_axi_awready = (st_r.bus == crf_pkg::BUS_IDLE) & ~st_r.aw_seen;
   assign s_axi_wready = (st_r.bus == crf_pkg::BUS_IDLE) & ~st_r.w_seen;
   assign s_axi_arready = (st_r.bus == crf_pkg::BUS_IDLE) & ~st_r.aw_seen & ~st_r.w_seen
                          & ~s_axi_awvalid & ~s_axi_wvalid;
   assign s_axi_bvalid = st_r.bus == crf_pkg::BUS_WRESP;
   assign s_axi_rvalid = st_r.bus == crf_pkg::BUS_RRESP;
   assign s_axi_bresp = st_r.resp;
   assign s_axi_rresp = st_r.resp;
   assign s_axi_rdata = st_r.rdata;
   // Write lands a cycle after both halves; costs a cycle, keeps decode off the pins
   assign do_write = st_r.aw_seen & st_r.w_seen & (st_r.bus == crf_pkg::BUS_IDLE);
   assign clear_mask = (do_write && st_r.waddr == crf_pkg::ADDR_FLAGS && st_r.wstrb[0]
                        && out_init) ? st_r.wdata[7:0] : 8'h00;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   // All state decided here; flops only register it
   always_comb begin
      st_nxt = st_r;
      shift_foreground = 1'b0;
      // Bus channel capture, either order
      if (s_axi_awvalid & s_axi_awready) begin
         st_nxt.aw_seen = 1'b1;
         st_nxt.waddr = s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
         st_nxt.w_seen = 1'b1;
         st_nxt.wdata = s_axi_wdata;
         st_nxt.wstrb = s_axi_wstrb;
      end
      // Register write, one cycle after both halves are in
      if (do_write) begin
         st_nxt.aw_seen = 1'b0;
         st_nxt.w_seen = 1'b0;
         st_nxt.bus = crf_pkg::BUS_WRESP;
         st_nxt.resp = crf_pkg::AXI_OKAY;
         case (st_r.waddr)
            crf_pkg::ADDR_FLAGS: begin
            end
            crf_pkg::ADDR_ENABLES: begin
               if (out_init && st_r.wstrb[0]) st_nxt.enables = st_r.wdata[7:0];
            end
            crf_pkg::ADDR_CTRL: begin
               if (st_r.wstrb[0]) begin
                  st_nxt.init_request = st_r.wdata[crf_pkg::BIT_INIT_REQ];
                  st_nxt.wakeup_enable = st_r.wdata[crf_pkg::BIT_WAKE_EN];
               end
            end
            default: st_nxt.resp = crf_pkg::AXI_SLVERR;
         endcase
      end
      // Read
      if (s_axi_arvalid & s_axi_arready) begin
         st_nxt.bus = crf_pkg::BUS_RRESP;
         st_nxt.resp = crf_pkg::AXI_OKAY;
         case (s_axi_araddr)
            crf_pkg::ADDR_FLAGS: st_nxt.rdata = {24'h000000, flags_rd};
            crf_pkg::ADDR_ENABLES: st_nxt.rdata = {24'h000000, st_r.enables};
            crf_pkg::ADDR_CTRL: st_nxt.rdata = {29'h00000000, st_r.init_acknowledge,
                                                st_r.wakeup_enable, st_r.init_request};
            default: begin
               st_nxt.rdata = 32'h00000000;
               st_nxt.resp = crf_pkg::AXI_SLVERR;
            end
         endcase
      end
      if ((st_r.bus == crf_pkg::BUS_WRESP && s_axi_bready)
          || (st_r.bus == crf_pkg::BUS_RRESP && s_axi_rready)) begin
         st_nxt.bus = crf_pkg::BUS_IDLE;
      end
      // Acknowledge follows the request one cycle later
      st_nxt.init_acknowledge = st_r.init_request;

      st_nxt.flags.wakeup = st_r.flags.wakeup & ~clear_mask[crf_pkg::BIT_WAKEUP];
      st_nxt.flags.status_change = st_r.flags.status_change
                                   & ~clear_mask[crf_pkg::BIT_STATUS_CHANGE];
      st_nxt.flags.overrun = st_r.flags.overrun & ~clear_mask[crf_pkg::BIT_OVERRUN];
      st_nxt.flags.rx_full = st_r.flags.rx_full & ~clear_mask[crf_pkg::BIT_RX_FULL];
      if (core_events.overrun) st_nxt.flags.overrun = 1'b1;
      // wakeup on bus activity while asleep
      if (core_events.wakeup_activity && core_events.sleep_mode && st_r.wakeup_enable) begin
         st_nxt.flags.wakeup = 1'b1;
      end
      // A good message waits until the foreground buffer is free
      if (core_events.rx_message_ok) st_nxt.rx_pending = 1'b1;
      // no shift while full; shift sets full
      if ((st_r.rx_pending || core_events.rx_message_ok) && !st_r.flags.rx_full) begin
         shift_foreground = 1'b1;
         st_nxt.flags.rx_full = 1'b1;
         st_nxt.rx_pending = 1'b0;
      end

      // fields frozen while change flag pending
      if (!st_r.flags.status_change) begin
         st_nxt.receiver_state_field = rx_live;
         st_nxt.transmitter_state_field = tx_live;
         if (sens_hit(st_r.enables.receiver_sensitivity, st_r.receiver_state_field, rx_live)
             || sens_hit(st_r.enables.transmitter_sensitivity,
                         st_r.transmitter_state_field, tx_live)) begin
            st_nxt.flags.status_change = 1'b1;
         end
      end

      // held in reset during init mode; fields and sensitivity kept
      if (in_init) begin
         st_nxt.flags = crf_pkg::FLAGS_RESET[3:0];
         st_nxt.rx_pending = 1'b0;
         st_nxt.enables.wakeup_irq_enable = 1'b0;
         st_nxt.enables.status_change_irq_enable = 1'b0;
         st_nxt.enables.overrun_irq_enable = 1'b0;
         st_nxt.enables.receive_full_irq_enable = 1'b0;
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   // Synchronous active-low reset
   // Bus state set by name so idle never depends on the enum encoding
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
         st_r.enables <= crf_pkg::ENABLES_RESET;
         st_r.bus <= crf_pkg::BUS_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // Interrupt outputs
   // ----------------------------------------
   // wakeup request gated by its enable
   assign irq_wakeup = st_r.flags.wakeup & st_r.enables.wakeup_irq_enable;
   // error request from change or overrun
   assign irq_error = (st_r.flags.status_change & st_r.enables.status_change_irq_enable)
                      | (st_r.flags.overrun & st_r.enables.overrun_irq_enable);
   // receiver request gated by its enable
   assign irq_receive = st_r.flags.rx_full & st_r.enables.receive_full_irq_enable;
   assign irq = irq_wakeup | irq_error | irq_receive;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // overrun sets flag
   chk_overrun_sets: assert property (@(posedge aclk) disable iff (!aresetn)
      core_events.overrun && !in_init |=> st_r.flags.overrun)
      else $error("overrun did not set flag");
   chk_no_shift_full: assert property (@(posedge aclk) disable iff (!aresetn)
      st_r.flags.rx_full |-> !shift_foreground)
      else $error("shift while buffer full");
   chk_shift_sets_full: assert property (@(posedge aclk) disable iff (!aresetn)
      shift_foreground && !in_init |=> st_r.flags.rx_full)
      else $error("shift did not set full");
   chk_busoff_mirror: assert property (@(posedge aclk) disable iff (!aresetn)
      st_r.transmitter_state_field == crf_pkg::ST_BUSOFF
      |-> st_r.receiver_state_field == crf_pkg::ST_BUSOFF)
      else $error("receiver not bus-off");
   chk_fields_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
      st_r.flags.status_change |=> $stable(st_r.receiver_state_field)
      && $stable(st_r.transmitter_state_field))
      else $error("state field moved while pending");
   chk_init_enables: assert property (@(posedge aclk) disable iff (!aresetn)
      in_init |=> !st_r.enables.overrun_irq_enable && !st_r.enables.receive_full_irq_enable)
      else $error("enables not held in init");
   chk_wake_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      irq_wakeup == (st_r.flags.wakeup && st_r.enables.wakeup_irq_enable))
      else $error("wakeup request wrong");
   chk_rx_irq: assert property (@(posedge aclk) disable iff (!aresetn)
      st_r.flags.rx_full && st_r.enables.receive_full_irq_enable |-> irq && irq_receive)
      else $error("receive request missing");
   chk_tx_code: assert property (@(posedge aclk) disable iff (!aresetn)
      !st_r.flags.status_change && tx_error_count > crf_pkg::LIMIT_BUSOFF
      |=> st_r.transmitter_state_field == crf_pkg::ST_BUSOFF)
      else $error("bus-off code wrong");
   chk_wake_sets: assert property (@(posedge aclk) disable iff (!aresetn)
      core_events.wakeup_activity && core_events.sleep_mode && st_r.wakeup_enable && !in_init
      |=> st_r.flags.wakeup)
      else $error("wakeup did not set flag");
   chk_change_irq: assert property (@(posedge aclk) disable iff (!aresetn)
      st_r.flags.status_change && st_r.enables.status_change_irq_enable |-> irq_error && irq)
      else $error("status change request missing");
   chk_overrun_irq: assert property (@(posedge aclk) disable iff (!aresetn)
      st_r.flags.overrun && st_r.enables.overrun_irq_enable |-> irq_error && irq)
      else $error("overrun request missing");
   chk_rx_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
      !st_r.enables.receive_full_irq_enable |-> !irq_receive)
      else $error("masked receive request raised");
   chk_write_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      clear_mask[crf_pkg::BIT_OVERRUN] && !core_events.overrun |=> !st_r.flags.overrun)
      else $error("write one did not clear");
   chk_write_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      st_r.flags.rx_full && !clear_mask[crf_pkg::BIT_RX_FULL] && !in_init
      |=> st_r.flags.rx_full)
      else $error("receive-full dropped without clear");
   chk_init_flags: assert property (@(posedge aclk) disable iff (!aresetn)
      in_init |=> st_r.flags == 4'h0)
      else $error("flags not held in init");
   chk_rx_sens_busoff: assert property (@(posedge aclk) disable iff (!aresetn)
      !st_r.flags.status_change && !in_init && st_r.enables.receiver_sensitivity == 2'h1
      && st_r.receiver_state_field != crf_pkg::ST_BUSOFF && rx_live == crf_pkg::ST_BUSOFF
      |=> st_r.flags.status_change)
      else $error("receiver bus-off change missed");
   chk_tx_sens_all: assert property (@(posedge aclk) disable iff (!aresetn)
      !st_r.flags.status_change && !in_init && st_r.enables.transmitter_sensitivity == 2'h3
      && st_r.transmitter_state_field != tx_live |=> st_r.flags.status_change)
      else $error("transmitter change missed");
   chk_sens_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
      !st_r.flags.status_change && st_r.enables.receiver_sensitivity == 2'h0
      && st_r.enables.transmitter_sensitivity == 2'h0 |=> !st_r.flags.status_change)
      else $error("change flagged with sensitivity off");
endmodule : crf_rx_flags

/* File: src/crf_pkg.sv */
// Package for the receive flag and interrupt-enable block: offsets, fields, types
package crf_pkg;
   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [3:0] ADDR_FLAGS = 4'h0;   // Receiver flags
   localparam logic [3:0] ADDR_ENABLES = 4'h4; // Receiver interrupt enables
   localparam logic [3:0] ADDR_CTRL = 4'h8;    // Init request, wakeup enable, init ack (ro)
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int BIT_WAKEUP = 7;
   localparam int BIT_STATUS_CHANGE = 6;
   localparam int BIT_OVERRUN = 1;
   localparam int BIT_RX_FULL = 0;
   localparam int BIT_INIT_REQ = 0;
   localparam int BIT_WAKE_EN = 1;
   localparam int BIT_INIT_ACK = 2;
   // ----------------------------------------
   // Reset values, thresholds and response codes
   // ----------------------------------------
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] ENABLES_RESET = 8'h00;
   localparam logic [8:0] LIMIT_WARN = 9'h060;  // 96
   localparam logic [8:0] LIMIT_ERR = 9'h07f;   // 127
   localparam logic [8:0] LIMIT_BUSOFF = 9'h0ff; // 255
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {ST_OK, ST_WARN, ST_ERR, ST_BUSOFF} crf_state_t;
   typedef enum {BUS_IDLE, BUS_WRESP, BUS_RRESP} crf_bus_t;
   // Sticky flags
   typedef struct packed {
      logic wakeup;
      logic status_change;
      logic overrun;
      logic rx_full;
   } crf_flags_t;
   // Interrupt enables and sensitivity
   typedef struct packed {
      logic wakeup_irq_enable;
      logic status_change_irq_enable;
      logic [1:0] receiver_sensitivity;
      logic [1:0] transmitter_sensitivity;
      logic overrun_irq_enable;
      logic receive_full_irq_enable;
   } crf_enables_t;
   // Events from the CAN core
   typedef struct packed {
      logic overrun;
      logic rx_message_ok;
      logic wakeup_activity;
      logic sleep_mode;
   } crf_events_t;
   // Whole state of the block
   typedef struct packed {
      crf_flags_t flags;
      crf_enables_t enables;
      crf_state_t receiver_state_field;
      crf_state_t transmitter_state_field;
      logic init_request;
      logic wakeup_enable;
      logic init_acknowledge;
      logic rx_pending;
      crf_bus_t bus;
      logic aw_seen;
      logic w_seen;
      logic [3:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic [31:0] rdata;
      logic [1:0] resp;
   } crf_state_all_t;
endpackage : crf_pkg

/* File: sim/crf_core_model.sv */
// Far-side model: CAN core event pulses and live error counters
`timescale 1ns/10ps
module crf_core_model (
   input wire logic aclk,
   output crf_pkg::crf_events_t core_events,
   output logic [8:0] tx_error_count,
   output logic [7:0] rx_error_count
);
   // Quiet bus and clean counters until told otherwise
   initial begin
      core_events = '0;
      tx_error_count = 9'h000;
      rx_error_count = 8'h00;
   end
   // ----------------------------------------
   // Event and counter drive
   // ----------------------------------------
   // one event pulse at the given index
   // One-cycle pulse; never used on the sleep bit, which is a level
   task automatic pulse(input int idx);
      @(posedge aclk);
      core_events[idx] <= 1'b1;
      @(posedge aclk);
      core_events[idx] <= 1'b0;
   endtask : pulse
   task automatic sleep(input logic on);
      @(posedge aclk);
      core_events.sleep_mode <= on;
   endtask : sleep
   // counter values
   // Counters jump in one step; the block must cope with any crossing
   task automatic counts(input logic [8:0] tx, input logic [7:0] rx);
      @(posedge aclk);
      tx_error_count <= tx;
      rx_error_count <= rx;
   endtask : counts
endmodule : crf_core_model

/* File: sim/tb.sv */
// Self-checking bench for the receive flag and interrupt-enable block
`timescale 1ns/10ps
module tb;
   typedef struct {int ev; logic [7:0] en; logic [7:0] fl; logic [3:0] ir;} crf_row_t;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   crf_pkg::crf_events_t core_events;
   logic [8:0] tx_error_count;
   logic [7:0] rx_error_count;
   logic shift_foreground, irq_wakeup, irq_error, irq_receive, irq;
   int err_total = 0, checks = 0, shifts = 0, shift_base = 0;
   // Interrupt lines as one word: wakeup, error, receive, any
   wire logic [31:0] irqv = {28'h0, irq_wakeup, irq_error, irq_receive, irq};
   // Ordinary cases: event index, enables, flags seen, interrupt lines
   crf_row_t rows [6] = '{'{3, 8'h02, 8'h02, 4'h5}, '{3, 8'h00, 8'h02, 4'h0},
      '{2, 8'h01, 8'h01, 4'h3}, '{2, 8'h00, 8'h01, 4'h0},
      '{1, 8'h80, 8'h80, 4'h9}, '{1, 8'h00, 8'h80, 4'h0}};
   crf_rx_flags u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_events,
      .tx_error_count, .rx_error_count, .shift_foreground, .irq_wakeup, .irq_error,
      .irq_receive, .irq);
   crf_core_model u_core (.aclk, .core_events, .tx_error_count, .rx_error_count);
   // 25 ns period
   always #12.5 aclk = ~aclk;
   // Count buffer moves into the foreground slot
   always @(posedge aclk) if (shift_foreground === 1'b1) shifts++;
   // ----------------------------------------
   // Checking and bus tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic test_done();
      $display("Counts: %0d compares, %0d mismatches", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done
   // A hung handshake ends the run as a mismatch
   task automatic hang();
      err_total++;
      test_done();
   endtask : hang
   // Both write parts offered together, each dropped once taken
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      // Ready stays high between calls; each call drives it high again and none lowers it
      rr = s_axi_bresp;
      if (n == 40) hang();
   endtask : wr
   task automatic rdr(input logic [3:0] a);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      if (n == 40) hang();
   endtask : rdr
   // Short forms for the two registers
   task automatic rf(input logic [7:0] e);
      rdr(crf_pkg::ADDR_FLAGS);
      chk(rd, {24'h0, e});
   endtask : rf
   task automatic re(input logic [7:0] e);
      rdr(crf_pkg::ADDR_ENABLES);
      chk(rd, {24'h0, e});
   endtask : re
   task automatic wf(input logic [7:0] d);
      wr(crf_pkg::ADDR_FLAGS, d);
   endtask : wf
   task automatic we(input logic [7:0] d);
      wr(crf_pkg::ADDR_ENABLES, d);
   endtask : we
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rf(crf_pkg::FLAGS_RESET);
      re(crf_pkg::ENABLES_RESET);
      $display("reset test done");
      // Wakeup needs the enable in ctrl and the core asleep
      wr(crf_pkg::ADDR_CTRL, 8'h02);
      u_core.sleep(1'b1);
      foreach (rows[i]) begin
         we(rows[i].en);
         u_core.pulse(rows[i].ev);
         @(posedge aclk);
         rf(rows[i].fl);
         chk(irqv, {28'h0, rows[i].ir});
         wf(8'h00);
         rf(rows[i].fl);
         wf(rows[i].fl);
         rf(8'h00);
      end
      u_core.sleep(1'b0);
      $display("row tests done");
      // Second frame must wait behind a full foreground buffer
      shift_base = shifts;
      u_core.pulse(2);
      u_core.pulse(2);
      @(posedge aclk);
      chk(shifts - shift_base, 1);
      wf(8'h01);
      repeat (2) @(posedge aclk);
      chk(shifts - shift_base, 2);
      rf(8'h01);
      wf(8'h01);
      $display("hold test done");
      // Bus-off entry, freeze while pending, jump back to OK
      we(8'h44);
      u_core.counts(9'h12c, 8'h00);
      repeat (3) @(posedge aclk);
      rf(8'h7c);
      chk(irqv, 32'h5);
      u_core.counts(9'h000, 8'h00);
      repeat (3) @(posedge aclk);
      rf(8'h7c);
      wf(8'h40);
      repeat (3) @(posedge aclk);
      rf(8'h40);
      wf(8'h40);
      // Sensitivity 00 stays quiet, 10 catches the error boundary
      we(8'h40);
      u_core.counts(9'h064, 8'h00);
      repeat (3) @(posedge aclk);
      rf(8'h04);
      we(8'h48);
      u_core.counts(9'h080, 8'h00);
      repeat (3) @(posedge aclk);
      rf(8'h48);
      we(8'h40);
      u_core.counts(9'h000, 8'h64);
      wf(8'h40);
      repeat (3) @(posedge aclk);
      rf(8'h10);
      // Receiver code 11 flags a warning-level change
      we(8'h70);
      u_core.counts(9'h000, 8'h00);
      repeat (3) @(posedge aclk);
      rf(8'h40);
      we(8'h40);
      wf(8'h40);
      repeat (3) @(posedge aclk);
      rf(8'h00);
      $display("state tests done");
      // Init mode resets enables but keeps sensitivity and state fields
      we(8'hb3);
      re(8'hb3);
      u_core.counts(9'h064, 8'h00);
      wr(crf_pkg::ADDR_CTRL, 8'h01);
      repeat (3) @(posedge aclk);
      re(8'h30);
      rdr(crf_pkg::ADDR_CTRL);
      chk(rd, 32'h5);
      we(8'hff);
      chk({30'h0, rr}, {30'h0, crf_pkg::AXI_OKAY});
      re(8'h30);
      rf(8'h04);
      wr(crf_pkg::ADDR_CTRL, 8'h00);
      repeat (3) @(posedge aclk);
      we(8'hff);
      re(8'hff);
      rdr(4'hc);
      chk({30'h0, rr}, {30'h0, crf_pkg::AXI_SLVERR});
      wr(4'hc, 8'h00);
      chk({30'h0, rr}, {30'h0, crf_pkg::AXI_SLVERR});
      $display("init test done");
      // Mid-run reset drops a raised overrun request and the enables
      u_core.pulse(3);
      @(posedge aclk);
      chk(irqv, 32'h5);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk(irqv, 32'h0);
      re(crf_pkg::ENABLES_RESET);
      rf(8'h04);
      $display("mid-run reset test done");
      test_done();
   end
endmodule : tb
